/* design/lmc_map.svh */
// Constants of the mode-control and wake-up block of a single-wire transceiver.
// Assumes a 250 MHz system clock; every time is held in its own unit.
`ifndef LMC_MAP_SVH
`define LMC_MAP_SVH

// -----------------------------------------------------------------------------
// Clock and time base
// -----------------------------------------------------------------------------
`define LMC_CLK_PERIOD_PS     4000
`define LMC_TICK_PS           1000000
// Cycles per 1 us tick, a least figure so rounded up
`define LMC_TICK_CYCLES       ((`LMC_TICK_PS + `LMC_CLK_PERIOD_PS - 1) / `LMC_CLK_PERIOD_PS)

// -----------------------------------------------------------------------------
// Filter and settle times, in microseconds, counted in ticks
// -----------------------------------------------------------------------------
`define LMC_BUS_WAKE_FILTER_US    100
`define LMC_LOCAL_WAKE_FILTER_US  50
`define LMC_MODE_SETTLE_US        10

// -----------------------------------------------------------------------------
// Link rate and transmit buffer
// -----------------------------------------------------------------------------
`define LMC_MAX_BIT_RATE_BPS  20000
`define LMC_TX_FIFO_DEPTH     32
`define LMC_TX_FIFO_WIDTH     1

// -----------------------------------------------------------------------------
// Reset values of pin drivers
// -----------------------------------------------------------------------------
`define LMC_RXD_LEVEL         1'h0
`define LMC_REG_CTRL_LEVEL    1'h1

`endif

/* design/lmc_pkg.sv */
// Types shared by the mode-control block.
// Assumes the constants header is compiled alongside.
package lmc_pkg;

    // -------------------------------------------------------------------------
    // Operating modes, one-hot
    // -------------------------------------------------------------------------
    typedef enum logic [3:0] {
        LMC_POR     = 4'h1,
        LMC_SLEEP   = 4'h2,
        LMC_STANDBY = 4'h4,
        LMC_NORMAL  = 4'h8
    } lmc_mode_t;

endpackage

/* design/lmc_top.sv */
// Mode sequencing, wake-up filtering and pin control of a single-wire transceiver,
// plus the transmit FIFO that sits between the host transmit pin and the bus driver.
// Assumes all pins are synchronous to clk_in and that the pad ring resolves
// the output enables into wire levels.
//
// Notes on behaviour
// - Normal mode: transmit goes to bus; receive shows bus, high recessive, low dominant.
// - Bus transmission in normal mode supported up to 20 kbps.
// - Mode request rising in sleep or standby enters normal mode.
// - Mode request driven low enters sleep mode.
// - Sleep: driver, receiver, termination off; weak pullup; receive floats; regulator hi-Z.
// - Sleep keeps request, local wake, bus wake active; request high wakes locally.
// - Remote wake: dominant held at least bus filter time, then recessive again.
// - Local wake: local wake input low longer than its filter time.
// - Bus or local wake drives receive low and moves sleep to standby.
// - Entering normal from standby releases wake request; receive follows the bus.
// - Standby after wake: transmit pin high for remote, strongly low for local.
// - Standby: termination on, regulator control high, transmitter off.
// - Power-up: request low gives standby, high gives normal; floating reads low.
// - Held in power-on reset while supply is below undervoltage threshold.
// - After undervoltage with request low, receive is driven low showing standby.
// - Each mode change by request takes effect only after mode settle time from request change; the code can act after just over MODE_TICKS - 1 ticks.
// - Normal: bus dominant while transmit low, recessive while transmit high.
// - Bus dominant on sleep entry locks out bus wake until bus goes recessive.

`include "lmc_map.svh"

// -----------------------------------------------------------------------------
// Transmit FIFO
// -----------------------------------------------------------------------------
module lmc_fifo #(
    parameter int WIDTH = `LMC_TX_FIFO_WIDTH,
    parameter int DEPTH = `LMC_TX_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             flush_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("lmc_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    wire              full;
    wire              empty;
    wire              push;
    wire              pop;

    // Extra pointer bit tells full from empty
    assign full          = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                           (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign empty         = (wr_ptr_q == rd_ptr_q);
    assign push          = in_valid_in && !full && !flush_in;
    assign pop           = !empty && out_ready_in && !flush_in;
    assign in_ready_out  = !full && !flush_in;
    assign out_valid_out = !empty;
    assign out_data_out  = mem_q[rd_ptr_q[AW-1:0]];

    // Storage, no reset needed on data
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
        end
    end

    // Pointers
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (flush_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
            end
        end
    end
endmodule

// -----------------------------------------------------------------------------
// Mode control top
// -----------------------------------------------------------------------------
module lmc_top
    import lmc_pkg::*;
#(
    parameter int TICK_CYCLES      = `LMC_TICK_CYCLES,
    parameter int BUS_WAKE_TICKS   = `LMC_BUS_WAKE_FILTER_US,
    parameter int LOCAL_WAKE_TICKS = `LMC_LOCAL_WAKE_FILTER_US,
    parameter int MODE_TICKS       = `LMC_MODE_SETTLE_US,
    parameter int FIFO_DEPTH       = `LMC_TX_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic      clk_in,
    input  wire logic      arst_n_in,
    // Supply monitor, low while below the undervoltage threshold
    input  wire logic      supply_ok_in,
    // Host side
    input  wire logic      mode_req_in,
    input  wire logic      txd_in,
    output logic           txd_out,
    output logic           txd_oe_out,
    output logic           rxd_out,
    output logic           rxd_oe_out,
    output logic           tx_ready_out,
    // Local wake switch, active low
    input  wire logic      local_wake_in,
    // Bus side, bus_in high means recessive
    input  wire logic      bus_in,
    output logic           bus_out,
    output logic           bus_oe_out,
    output logic           term_on_out,
    output logic           weak_pullup_out,
    // Regulator control
    output logic           regulator_ctrl_out,
    output logic           regulator_ctrl_oe_out,
    // Status
    output lmc_pkg::lmc_mode_t mode_out
);
    import lmc_pkg::*;

    localparam int CW = 16;

    // Clock must resolve a bit of the top rate into at least one tick of the filters
    initial begin
        if (TICK_CYCLES < 1 || BUS_WAKE_TICKS < 1 || LOCAL_WAKE_TICKS < 1 ||
            MODE_TICKS < 1 || BUS_WAKE_TICKS >= (1 << CW) ||
            LOCAL_WAKE_TICKS >= (1 << CW) || MODE_TICKS >= (1 << CW) ||
            TICK_CYCLES * `LMC_MAX_BIT_RATE_BPS > 1000000 * TICK_CYCLES) begin
            $error("lmc_top: unsupported timing parameters");
        end
    end

    // -------------------------------------------------------------------------
    // Time base
    // -------------------------------------------------------------------------
    logic [CW-1:0] div_q;
    logic          tick_q;

    // One-cycle tick every microsecond
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == CW'(TICK_CYCLES - 1));
            div_q  <= (div_q == CW'(TICK_CYCLES - 1)) ? '0 : div_q + CW'(1);
        end
    end

    // -------------------------------------------------------------------------
    // Mode request edge and settle timer
    // -------------------------------------------------------------------------
    lmc_mode_t     mode_q;
    lmc_mode_t     mode_d;
    logic          req_last_q;
    logic          settle_busy_q;
    logic [CW-1:0] settle_cnt_q;
    wire           req_edge;
    wire           settle_done;

    assign req_edge    = (mode_req_in != req_last_q);
    assign settle_done = settle_busy_q && tick_q && (settle_cnt_q == CW'(MODE_TICKS - 1));

    // Any change of the request restarts the wait
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            req_last_q    <= 1'b0;
            settle_busy_q <= 1'b0;
            settle_cnt_q  <= '0;
        end else begin
            req_last_q <= mode_req_in;
            if (req_edge || mode_q == LMC_POR) begin
                settle_busy_q <= (mode_q != LMC_POR);
                settle_cnt_q  <= '0;
            end else if (settle_done) begin
                settle_busy_q <= 1'b0;
            end else if (settle_busy_q && tick_q) begin
                settle_cnt_q <= settle_cnt_q + CW'(1);
            end
        end
    end

    // -------------------------------------------------------------------------
    // Wake filters
    // -------------------------------------------------------------------------
    logic          lockout_q;
    logic          bus_armed_q;
    logic [CW-1:0] bus_cnt_q;
    logic [CW-1:0] loc_cnt_q;
    logic          wake_local_q;
    wire           in_sleep;
    wire           bus_dom;
    wire           remote_wake;
    wire           local_wake;
    wire           bus_cnt_hit;
    wire           loc_cnt_hit;

    assign in_sleep    = (mode_q == LMC_SLEEP);
    assign bus_dom     = !bus_in;
    assign bus_cnt_hit = (bus_cnt_q == CW'(BUS_WAKE_TICKS));
    assign loc_cnt_hit = (loc_cnt_q == CW'(LOCAL_WAKE_TICKS));
    // Dominant long enough, then back to recessive
    assign remote_wake = in_sleep && !lockout_q && (bus_armed_q || bus_cnt_hit) && !bus_dom;
    // Strictly longer than the filter time
    assign local_wake  = in_sleep && !local_wake_in && loc_cnt_hit && tick_q;

    // Bus filter with stuck-dominant lockout
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lockout_q   <= 1'b0;
            bus_armed_q <= 1'b0;
            bus_cnt_q   <= '0;
        end else if (!in_sleep) begin
            lockout_q   <= bus_dom;
            bus_armed_q <= 1'b0;
            bus_cnt_q   <= '0;
        end else if (lockout_q) begin
            lockout_q <= bus_dom;
            bus_cnt_q <= '0;
        end else if (!bus_dom) begin
            bus_armed_q <= 1'b0;
            bus_cnt_q   <= '0;
        end else if (tick_q && !bus_cnt_hit) begin
            bus_cnt_q <= bus_cnt_q + CW'(1);
        end else if (bus_cnt_hit) begin
            bus_armed_q <= 1'b1;
        end
    end

    // Local filter; the lockout only concerns the bus
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            loc_cnt_q <= '0;
        end else if (!in_sleep || local_wake_in) begin
            loc_cnt_q <= '0;
        end else if (tick_q && !loc_cnt_hit) begin
            loc_cnt_q <= loc_cnt_q + CW'(1);
        end
    end

    // -------------------------------------------------------------------------
    // Mode machine
    // -------------------------------------------------------------------------
    // Request changes only act once the settle timer expires
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            LMC_POR: begin
                if (supply_ok_in) begin
                    mode_d = mode_req_in ? LMC_NORMAL : LMC_STANDBY;
                end
            end
            LMC_SLEEP: begin
                if (settle_done && mode_req_in) begin
                    mode_d = LMC_NORMAL;
                end else if (remote_wake || local_wake) begin
                    mode_d = LMC_STANDBY;
                end
            end
            LMC_STANDBY: begin
                if (settle_done && mode_req_in) begin
                    mode_d = LMC_NORMAL;
                end else if (settle_done) begin
                    mode_d = LMC_SLEEP;
                end
            end
            LMC_NORMAL: begin
                if (settle_done && !mode_req_in) begin
                    mode_d = LMC_SLEEP;
                end
            end
            default: begin
                mode_d = LMC_POR;
            end
        endcase
        if (!supply_ok_in) begin
            mode_d = LMC_POR;
        end
    end

    // State and remembered wake source
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_q       <= LMC_POR;
            wake_local_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            if (mode_d != LMC_STANDBY) begin
                wake_local_q <= 1'b0;
            end else if (in_sleep) begin
                wake_local_q <= local_wake;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Transmit path through the FIFO
    // -------------------------------------------------------------------------
    // Samples queue while the settle timer runs so no bit is lost; the host
    // sees tx_ready_out drop if the wait outlasts the buffer.
    wire in_normal;
    wire tx_run;
    wire fifo_valid;
    wire fifo_data;
    wire fifo_ready;

    assign in_normal = (mode_q == LMC_NORMAL);
    assign tx_run    = in_normal && !settle_busy_q;

    lmc_fifo #(
        .WIDTH (`LMC_TX_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .arst_n_in     (arst_n_in),
        .flush_in      (!in_normal),
        .in_valid_in   (in_normal),
        .in_ready_out  (fifo_ready),
        .in_data_in    (txd_in),
        .out_valid_out (fifo_valid),
        .out_ready_in  (tx_run),
        .out_data_out  (fifo_data)
    );

    // -------------------------------------------------------------------------
    // Pin drivers, all registered
    // -------------------------------------------------------------------------
    wire in_standby;
    wire drive_dom;

    assign in_standby = (mode_q == LMC_STANDBY);
    // Latency grows with the queue fill, up to the buffer depth, yet stays far below one bit at the top rate
    assign drive_dom  = tx_run && fifo_valid && !fifo_data;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_out               <= 1'b0;
            bus_oe_out            <= 1'b0;
            rxd_out               <= `LMC_RXD_LEVEL;
            rxd_oe_out            <= 1'b0;
            txd_out               <= 1'b0;
            txd_oe_out            <= 1'b0;
            term_on_out           <= 1'b0;
            weak_pullup_out       <= 1'b0;
            regulator_ctrl_out    <= `LMC_REG_CTRL_LEVEL;
            regulator_ctrl_oe_out <= 1'b0;
            tx_ready_out          <= 1'b0;
            mode_out              <= LMC_POR;
        end else begin
            bus_out               <= 1'b0;
            bus_oe_out            <= drive_dom;
            rxd_out               <= `LMC_RXD_LEVEL;
            // Open drain: pull low for dominant in normal or throughout standby, after wake or power-up
            rxd_oe_out            <= (in_normal && bus_dom) || in_standby;
            txd_out               <= 1'b0;
            txd_oe_out            <= in_standby && wake_local_q;
            term_on_out           <= in_normal || in_standby;
            weak_pullup_out       <= in_sleep;
            regulator_ctrl_out    <= `LMC_REG_CTRL_LEVEL;
            regulator_ctrl_oe_out <= in_normal || in_standby;
            tx_ready_out          <= fifo_ready;
            mode_out              <= mode_q;
        end
    end
endmodule

/* tb/lmc_top_sva.sv */
// Concurrent checks on the pins of the mode-control top.
// Assumes the lmc_pkg package is compiled first; bound to every lmc_top.
module lmc_top_sva
    import lmc_pkg::*;
#(
    parameter int TICK_CYCLES = 2,
    parameter int MODE_TICKS  = 2
) (
    // Clock and reset
    input wire logic               clk_in,
    input wire logic               arst_n_in,
    // Inputs watched
    input wire logic               supply_ok_in,
    input wire logic               mode_req_in,
    input wire logic               txd_in,
    input wire logic               bus_in,
    // Outputs watched
    input wire logic               txd_oe_out,
    input wire logic               rxd_oe_out,
    input wire logic               bus_oe_out,
    input wire logic               term_on_out,
    input wire logic               weak_pullup_out,
    input wire logic               regulator_ctrl_oe_out,
    input wire lmc_pkg::lmc_mode_t mode_out
);
    // Lower bound loose by three cycles; tick phase is not visible here
    localparam int SETTLE_MIN = (MODE_TICKS - 1) * TICK_CYCLES - 1;
    localparam int SETTLE_MAX = MODE_TICKS * TICK_CYCLES + 4;

    logic       req_q;
    logic [7:0] req_cnt_q;

    // Cycles since the mode request last changed, saturating
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            req_q     <= 1'h0;
            req_cnt_q <= 8'h00;
        end else begin
            req_q     <= mode_req_in;
            req_cnt_q <= (mode_req_in != req_q) ? 8'h00 :
                         (req_cnt_q == 8'hFF) ? req_cnt_q : req_cnt_q + 8'h01;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    chk_sleep_pins: assert property (mode_out == LMC_SLEEP |-> weak_pullup_out && !term_on_out
        && !rxd_oe_out && !regulator_ctrl_oe_out && !bus_oe_out) else $error("sleep pins wrong");
    chk_standby_pins: assert property (mode_out == LMC_STANDBY |-> rxd_oe_out && term_on_out
        && regulator_ctrl_oe_out && !bus_oe_out) else $error("standby pins wrong");
    chk_rx_follows_bus: assert property ((mode_out == LMC_NORMAL && !bus_in)[*3]
        |-> rxd_oe_out) else $error("receive misses dominant bus");
    chk_tx_dominant: assert property ((mode_out == LMC_NORMAL && !txd_in)[*6]
        |-> bus_oe_out) else $error("bus not driven for low transmit");
    chk_tx_recessive: assert property ((mode_out == LMC_NORMAL && txd_in)[*6]
        |-> !bus_oe_out) else $error("bus driven for high transmit");
    chk_settle_min: assert property ($changed(mode_out) && $past(mode_out) != LMC_POR
        && mode_out inside {LMC_NORMAL, LMC_SLEEP} |-> req_cnt_q >= SETTLE_MIN)
        else $error("mode changed before settle time");
    chk_req_low_sleep: assert property (!mode_req_in && req_cnt_q == SETTLE_MAX
        && mode_out != LMC_POR |-> mode_out != LMC_NORMAL) else $error("low request kept normal");
    chk_req_high_norm: assert property (mode_req_in && req_cnt_q == SETTLE_MAX && supply_ok_in
        && mode_out != LMC_POR |-> mode_out == LMC_NORMAL) else $error("high request not normal");
    chk_powerup_mode: assert property ($past(mode_out) == LMC_POR && mode_out != LMC_POR
        |-> mode_out == ($past(mode_req_in) ? LMC_NORMAL : LMC_STANDBY))
        else $error("power-up mode wrong");
    chk_undervolt_por: assert property ((!supply_ok_in)[*3] |-> mode_out == LMC_POR)
        else $error("no power-on state on low supply");
    chk_wake_src_pin: assert property (txd_oe_out |-> mode_out == LMC_STANDBY)
        else $error("transmit pin pulled outside standby");
endmodule

bind lmc_top lmc_top_sva #(.TICK_CYCLES(TICK_CYCLES), .MODE_TICKS(MODE_TICKS)) i_sva (
    .clk_in, .arst_n_in, .supply_ok_in, .mode_req_in, .txd_in, .bus_in, .txd_oe_out,
    .rxd_oe_out, .bus_oe_out, .term_on_out, .weak_pullup_out, .regulator_ctrl_oe_out, .mode_out
);

/* tb/lmc_far_end.sv */
// Far side of the transceiver: bus with a remote node, host pins with pull-ups.
// Assumes enables are high while the device pulls a wire low.
module lmc_far_end (
    // Clock
    input  wire logic clk_in,
    // Device pull-down enables
    input  wire logic bus_oe_in,
    input  wire logic txd_oe_in,
    input  wire logic rxd_oe_in,
    // Host transmit level and remote node
    input  wire logic txd_host_in,
    input  wire logic remote_dom_in,
    input  wire logic slow_in,
    // Resolved wire levels
    output logic      bus_out,
    output logic      txd_pin_out,
    output logic      rxd_pin_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic dom_q;

    // Slow remote node lags its edges by one cycle
    always_ff @(posedge clk_in) begin
        dom_q <= remote_dom_in;
    end

    // Pull-ups win whenever nobody pulls low, so released wires read high
    assign bus_out     = !(bus_oe_in || (slow_in ? dom_q : remote_dom_in));
    assign txd_pin_out = txd_host_in && !txd_oe_in;
    assign rxd_pin_out = !rxd_oe_in;
endmodule

/* tb/lmc_top_tb.sv */
// Self-checking bench for the mode-control top with a small time base.
// Assumes the design, package, checker and far-side model are compiled first.
module lmc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lmc_pkg::*;

    typedef struct packed {lmc_mode_t mode; logic rxd; logic txd;} lmc_note_t;

    logic      clk_in, arst_n_in, supply_ok_in, mode_req_in, txd_in, local_wake_in;
    logic      bus_in, txd_out, txd_oe_out, rxd_out, rxd_oe_out, tx_ready_out;
    logic      bus_out, bus_oe_out, term_on_out, weak_pullup_out;
    logic      regulator_ctrl_out, regulator_ctrl_oe_out, remote_dom, slow, txd_pin, rxd_pin;
    lmc_mode_t mode_out, last_mode;
    lmc_note_t exp_q[$];
    lmc_note_t nt;
    int        n_errors, tests_run, i;
    logic [31:0] rnd;

    lmc_top #(.TICK_CYCLES(2), .BUS_WAKE_TICKS(4), .LOCAL_WAKE_TICKS(3), .MODE_TICKS(2)) i_dut (
        .clk_in, .arst_n_in, .supply_ok_in, .mode_req_in, .txd_in, .txd_out, .txd_oe_out,
        .rxd_out, .rxd_oe_out, .tx_ready_out, .local_wake_in, .bus_in, .bus_out, .bus_oe_out,
        .term_on_out, .weak_pullup_out, .regulator_ctrl_out, .regulator_ctrl_oe_out, .mode_out);

    lmc_far_end i_far (.clk_in, .bus_oe_in(bus_oe_out), .txd_oe_in(txd_oe_out),
        .rxd_oe_in(rxd_oe_out), .txd_host_in(txd_in), .remote_dom_in(remote_dom),
        .slow_in(slow), .bus_out(bus_in), .txd_pin_out(txd_pin), .rxd_pin_out(rxd_pin));

    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic finish_test();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Inputs move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wait_mode(input lmc_mode_t m);
        for (int k = 0; k < 100 && mode_out !== m; k++) step(1);
        if (mode_out !== m) begin
            n_errors++;
            finish_test();
        end
    endtask

    // Host sets the request level and notes the mode it must bring
    task automatic go(input logic req, input lmc_mode_t m, input logic rx, input logic tx);
        exp_q.push_back('{m, rx, tx});
        mode_req_in = req;
        wait_mode(m);
        step(4);
    endtask

    // Bus node holds dominant, then releases
    task automatic remote(input int n, input logic wakes);
        if (wakes) exp_q.push_back('{LMC_STANDBY, 1'h0, 1'h1});
        remote_dom = 1'h1;
        step(n);
        remote_dom = 1'h0;
        step(20);
    endtask

    // -------------------------------------------------------------------------
    // Monitor: each mode change takes the oldest note
    // -------------------------------------------------------------------------
    always @(negedge clk_in) begin
        if (arst_n_in && mode_out !== last_mode) begin
            if (exp_q.size() == 0) begin
                check("unnoted mode", mode_out, last_mode);
            end else begin
                nt = exp_q.pop_front();
                check("mode", mode_out, nt.mode);
                check("receive pin", rxd_pin, nt.rxd);
                check("transmit pin", txd_pin, nt.txd);
                check("fixed levels", {txd_out, rxd_out, bus_out, regulator_ctrl_out}, 4'h1);
            end
            last_mode = mode_out;
        end
    end

    initial begin
        clk_in = 1'h0;
        forever #2 clk_in = !clk_in;
    end

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        {arst_n_in, remote_dom, slow} = 3'h0;
        {supply_ok_in, txd_in, local_wake_in, mode_req_in} = 4'hE;
        last_mode = LMC_POR;
        rnd = 32'h0631;
        n_errors = 0;
        tests_run = 0;
        step(16);
        arst_n_in = 1'h1;
        go(1'h0, LMC_STANDBY, 1'h0, 1'h1);
        go(1'h1, LMC_NORMAL, 1'h1, 1'h1);
        for (i = 0; i < 60; i++) begin
            rnd = xs(rnd);
            txd_in = rnd[0];
            step(1 + rnd[3:1]);
        end
        txd_in = 1'h1;
        step(20);
        check("tx ready", tx_ready_out, 4'h1);
        // Request chatter keeps the settle timer busy, so the queue only fills
        for (i = 0; i < 30; i++) begin
            mode_req_in = 1'h0;
            step(1);
            mode_req_in = 1'h1;
            step(1);
        end
        check("tx ready", tx_ready_out, 4'h0);
        step(12);
        go(1'h0, LMC_SLEEP, 1'h1, 1'h1);
        remote(6, 1'h0);
        slow = 1'h1;
        remote(12, 1'h1);
        slow = 1'h0;
        go(1'h1, LMC_NORMAL, 1'h1, 1'h1);
        go(1'h0, LMC_SLEEP, 1'h1, 1'h1);
        local_wake_in = 1'h0;
        step(3);
        local_wake_in = 1'h1;
        step(20);
        exp_q.push_back('{LMC_STANDBY, 1'h0, 1'h0});
        local_wake_in = 1'h0;
        step(12);
        local_wake_in = 1'h1;
        wait_mode(LMC_STANDBY);
        step(5);
        check("wake source", txd_pin, 4'h0);
        go(1'h1, LMC_NORMAL, 1'h1, 1'h1);
        remote_dom = 1'h1;
        step(5);
        go(1'h0, LMC_SLEEP, 1'h1, 1'h1);
        step(30);
        remote_dom = 1'h0;
        step(20);
        remote(12, 1'h1);
        go(1'h1, LMC_NORMAL, 1'h1, 1'h1);
        go(1'h0, LMC_SLEEP, 1'h1, 1'h1);
        go(1'h1, LMC_NORMAL, 1'h1, 1'h1);
        exp_q.push_back('{LMC_POR, 1'h1, 1'h1});
        supply_ok_in = 1'h0;
        wait_mode(LMC_POR);
        exp_q.push_back('{LMC_NORMAL, 1'h1, 1'h1});
        supply_ok_in = 1'h1;
        wait_mode(LMC_NORMAL);
        go(1'h0, LMC_SLEEP, 1'h1, 1'h1);
        exp_q.push_back('{LMC_POR, 1'h1, 1'h1});
        supply_ok_in = 1'h0;
        wait_mode(LMC_POR);
        exp_q.push_back('{LMC_STANDBY, 1'h0, 1'h1});
        supply_ok_in = 1'h1;
        wait_mode(LMC_STANDBY);
        step(10);
        check("notes left", 4'(exp_q.size()), 4'h0);
        finish_test();
    end
endmodule
